// [design/wsw_pkg.sv]
// Constants shared by the watchdog, sleep and wake control block
package wsw_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int TOSC_NS         = 20;
    localparam int WDT_PERIOD_US   = 18_000;
    localparam int OST_TOSC        = 1024;
    localparam int OST_CYCLES      = OST_TOSC * TOSC_NS / CLK_PERIOD_NS;
    localparam int OST_W           = 11;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int            IDX_W          = 14;
    localparam logic [13:0]   IDX_STATUS     = 14'h0003;
    localparam logic [13:0]   IDX_OPTION     = 14'h0081;
    localparam logic [13:0]   IDX_CONFIG     = 14'h2007;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0]    OPTION_RESET   = 8'hff;
    localparam logic [7:0]    CONFIG_MASK    = 8'h7f;
    localparam int            OPT_PSA_BIT    = 3;
    localparam int            OPT_PS_LSB     = 0;
    localparam int            CFG_WATCHDOG_FUSE_ENABLE_BIT   = 2;
    localparam int            CFG_FOSC_LSB   = 0;
    localparam logic [1:0]    FOSC_RC        = 2'h3;
    localparam int            STAT_TO_BIT    = 4;
    localparam int            STAT_PD_BIT    = 3;
    localparam logic [31:0]   BUS_ZERO       = 32'h0000_0000;

    // ------------------------------------------------------------
    // Power control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_START
    } wsw_state_type;

endpackage : wsw_pkg

// [design/wsw_top.sv]
// Watchdog counter, shared prescaler and power-down / wake-up control
// Overview of operation
// - Watchdog counts its own RC oscillator ticks
// - Running timeout resets the whole device
// - Sleeping timeout wakes, execution simply continues
// - Fuse bit zero keeps watchdog disabled
// - Base timeout period is nominally 18 ms
// - Assigned prescaler stretches timeout up to 1:128
// - Clear or sleep zeroes counter and postscaler
// - Any timeout clears the timeout status flag
// - Sleep clears watchdog and power-down flag, sets timeout flag, stops oscillator
// - Port pins hold their state while asleep
// - Watchdog reset never drives master-clear pin
// - Wake on master clear, timeout, enabled interrupts
// - Wake needs individual enable, ignores global enable
// - Resume after sleep; vector only if global
// - Sleep prefetches the next sequential instruction
// - Pending enabled interrupt makes sleep wake immediately
// - Every wake-up zeroes the watchdog counter
// - Power-down flag set at power-up, cleared sleeping
// - Crystal modes wait 1024 periods after wake
// - Option bit 3 gives prescaler to watchdog
// - Prescaler count is never software visible
// - Watchdog ratio code 000 is 1:1, doubling
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps

module wsw_top
    import wsw_pkg::*;
#(
    parameter int RC_OSC_HZ      = 100_000,
    parameter int WDT_BASE_TICKS = WDT_PERIOD_US / 1000 * RC_OSC_HZ / 1000,
    parameter int OST_COUNT      = OST_CYCLES,
    parameter logic [7:0] CONFIG_RESET = 8'h7f
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CE_I,
    // Wishbone slave
    input  wire logic [15:0] ADR_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        WE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Pins
    input  wire logic        WDT_RC_OSC_I,
    input  wire logic        MASTER_CLEAR_PIN_N_I,
    // Processor core
    input  wire logic        SLEEP_INSTR_I,
    input  wire logic        CLEAR_WATCHDOG_INSTR_I,
    input  wire logic        GLOBAL_IRQ_ENABLE_I,
    input  wire logic [1:0]  IRQ_ENABLE_I,
    input  wire logic [1:0]  IRQ_FLAG_I,
    input  wire logic        TMR_TICK_I,
    input  wire logic        TMR_WRITE_I,
    output logic             TMR_INC_O,
    output logic             DEVICE_RESET_O,
    output logic             MAIN_OSC_DRIVE_EN_O,
    output logic             PORT_HOLD_O,
    output logic             SLEEPING_O,
    output logic             FETCH_NEXT_O,
    output logic             WAKE_O,
    output logic             VECTOR_JUMP_O,
    output logic             TIMEOUT_STATUS_FLAG_O,
    output logic             POWERDOWN_STATUS_FLAG_O
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Terminal count of the shared prescaler: watchdog 1:1..1:128,
    // timer 1:2..1:256
    function automatic logic [7:0] pre_term(input logic [2:0] ps, input logic for_wdt);
        pre_term = for_wdt ? (8'h7f >> (3'h7 - ps)) : (8'hff >> (3'h7 - ps));
    endfunction

    localparam logic [15:0] BASE_LAST = 16'(WDT_BASE_TICKS - 1);
    localparam logic [10:0] OST_LAST  = 11'(OST_COUNT - 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rc_s1_r, rc_s2_r, rc_s3_r, mc_s1_r, mc_s2_r;
    logic rc_s1_nxt, rc_s2_nxt, rc_s3_nxt, mc_s1_nxt, mc_s2_nxt;
    logic rc_tick, master_clear_pin_low;

    always_comb begin
        rc_s1_nxt = WDT_RC_OSC_I;
        rc_s2_nxt = rc_s1_r;
        rc_s3_nxt = rc_s2_r;
        mc_s1_nxt = MASTER_CLEAR_PIN_N_I;
        mc_s2_nxt = mc_s1_r;
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rc_s1_r <= 1'b0;
            rc_s2_r <= 1'b0;
            rc_s3_r <= 1'b0;
            mc_s1_r <= 1'b1;
            mc_s2_r <= 1'b1;
        end else if (CE_I) begin
            rc_s1_r <= rc_s1_nxt;
            rc_s2_r <= rc_s2_nxt;
            rc_s3_r <= rc_s3_nxt;
            mc_s1_r <= mc_s1_nxt;
            mc_s2_r <= mc_s2_nxt;
        end
    end

    // Free-running RC source, independent of the main oscillator
    assign rc_tick  = rc_s2_r & ~rc_s3_r;
    assign master_clear_pin_low = ~mc_s2_r;

    // ------------------------------------------------------------
    // Register file and Wishbone slave
    // ------------------------------------------------------------
    logic [7:0]  option_r, option_nxt;
    logic [7:0]  config_r, config_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic        to_flag_r, to_flag_nxt;
    logic        pd_flag_r, pd_flag_nxt;
    logic [13:0] bus_idx;
    logic        bus_req;
    logic        prescaler_assign_select;
    logic [2:0]  ps;
    logic        fuse_en;
    logic        rc_mode;

    assign bus_idx = ADR_I[15:2];
    assign bus_req = CYC_I & STB_I & ~ack_r;
    assign prescaler_assign_select     = option_r[OPT_PSA_BIT];
    assign ps      = option_r[OPT_PS_LSB +: 3];
    assign fuse_en = config_r[CFG_WATCHDOG_FUSE_ENABLE_BIT];
    assign rc_mode = (config_r[CFG_FOSC_LSB +: 2] == FOSC_RC);

    // The prescaler count has no address at all
    always_comb begin
        option_nxt = option_r;
        config_nxt = config_r;
        ack_nxt    = bus_req;
        dat_nxt    = BUS_ZERO;
        if (bus_req && WE_I && SEL_I[0]) begin
            case (bus_idx)
                IDX_OPTION: option_nxt = DAT_I[7:0];
                IDX_CONFIG: config_nxt = DAT_I[7:0] & CONFIG_MASK;
                default:    option_nxt = option_r;
            endcase
        end
        if (bus_req && !WE_I) begin
            case (bus_idx)
                IDX_OPTION: dat_nxt = {24'h000000, option_r};
                IDX_CONFIG: dat_nxt = {24'h000000, config_r};
                IDX_STATUS: dat_nxt = {24'h000000, 3'h0, to_flag_r, pd_flag_r, 3'h0};
                default:    dat_nxt = BUS_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            option_r <= OPTION_RESET;
            config_r <= CONFIG_RESET & CONFIG_MASK;
            ack_r    <= 1'b0;
            dat_r    <= BUS_ZERO;
        end else if (CE_I) begin
            option_r <= option_nxt;
            config_r <= config_nxt;
            ack_r    <= ack_nxt;
            dat_r    <= dat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Watchdog base counter and shared prescaler
    // ------------------------------------------------------------
    logic [15:0] base_r, base_nxt;
    logic [7:0]  pre_r, pre_nxt;
    logic        tmr_inc_r, tmr_inc_nxt;
    logic        base_wrap;
    logic        wdt_timeout;
    logic        wdt_clr;
    wsw_state_type state_r, state_nxt;

    assign base_wrap   = fuse_en & rc_tick & (base_r == BASE_LAST);
    assign wdt_timeout = base_wrap & (~prescaler_assign_select | (pre_r == pre_term(ps, 1'b1)));

    always_comb begin
        base_nxt    = base_r;
        pre_nxt     = pre_r;
        tmr_inc_nxt = 1'b0;
        if (!fuse_en) begin
            base_nxt = 16'h0000;
            if (prescaler_assign_select) begin
                pre_nxt = 8'h00;
            end
        end else if (wdt_clr) begin
            base_nxt = 16'h0000;
            if (prescaler_assign_select) begin
                pre_nxt = 8'h00;
            end
        end else if (rc_tick) begin
            base_nxt = base_wrap ? 16'h0000 : base_r + 16'h0001;
            if (prescaler_assign_select && base_wrap) begin
                pre_nxt = wdt_timeout ? 8'h00 : pre_r + 8'h01;
            end
        end
        // Timer side: clock stops with the main oscillator
        if (!prescaler_assign_select && state_r == ST_RUN) begin
            if (TMR_WRITE_I) begin
                pre_nxt = 8'h00;
            end else if (TMR_TICK_I) begin
                tmr_inc_nxt = (pre_r == pre_term(ps, 1'b0));
                pre_nxt     = tmr_inc_nxt ? 8'h00 : pre_r + 8'h01;
            end
        end else if (state_r == ST_RUN) begin
            tmr_inc_nxt = TMR_TICK_I & ~TMR_WRITE_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            base_r    <= 16'h0000;
            pre_r     <= 8'h00;
            tmr_inc_r <= 1'b0;
        end else if (CE_I) begin
            base_r    <= base_nxt;
            pre_r     <= pre_nxt;
            tmr_inc_r <= tmr_inc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sleep, wake and reset control
    // ------------------------------------------------------------
    logic [10:0] ost_r, ost_nxt;
    logic        osc_en_r, osc_en_nxt;
    logic        hold_r, hold_nxt;
    logic        rst_r, rst_nxt;
    logic        fetch_r, fetch_nxt;
    logic        wake_r, wake_nxt;
    logic        vec_r, vec_nxt;
    logic        sleep_r, sleep_nxt;
    logic        irq_wake;

    // Global enable plays no part in waking
    assign irq_wake = |(IRQ_ENABLE_I & IRQ_FLAG_I);

    always_comb begin
        state_nxt   = state_r;
        ost_nxt     = ost_r;
        osc_en_nxt  = osc_en_r;
        hold_nxt    = hold_r;
        to_flag_nxt = to_flag_r;
        pd_flag_nxt = pd_flag_r;
        rst_nxt     = 1'b0;
        fetch_nxt   = 1'b0;
        wake_nxt    = 1'b0;
        vec_nxt     = 1'b0;
        wdt_clr     = 1'b0;
        if (master_clear_pin_low) begin
            // Pin reset: flags stay for the cause check
            state_nxt  = ST_RUN;
            osc_en_nxt = 1'b1;
            hold_nxt   = 1'b0;
            ost_nxt    = 11'h000;
            rst_nxt    = 1'b1;
            wdt_clr    = 1'b1;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (wdt_timeout) begin
                        // Internal only; the master-clear pin is input-only here
                        rst_nxt = 1'b1;
                        wdt_clr = 1'b1;
                    end else if (SLEEP_INSTR_I) begin
                        state_nxt   = ST_SLEEP;
                        wdt_clr     = 1'b1;
                        pd_flag_nxt = 1'b0;
                        to_flag_nxt = 1'b1;
                        osc_en_nxt  = 1'b0;
                        hold_nxt    = 1'b1;
                        fetch_nxt   = 1'b1;
                    end else if (CLEAR_WATCHDOG_INSTR_I) begin
                        wdt_clr     = 1'b1;
                        to_flag_nxt = 1'b1;
                        pd_flag_nxt = 1'b1;
                    end
                end
                ST_SLEEP: begin
                    // A pending enabled flag at entry wakes on the next cycle
                    if (wdt_timeout || irq_wake) begin
                        wdt_clr = 1'b1;
                        if (rc_mode) begin
                            state_nxt  = ST_RUN;
                            osc_en_nxt = 1'b1;
                            hold_nxt   = 1'b0;
                            wake_nxt   = 1'b1;
                            vec_nxt    = GLOBAL_IRQ_ENABLE_I & ~wdt_timeout;
                        end else begin
                            state_nxt  = ST_START;
                            osc_en_nxt = 1'b1;
                            ost_nxt    = 11'h000;
                        end
                    end
                end
                ST_START: begin
                    if (ost_r == OST_LAST) begin
                        state_nxt = ST_RUN;
                        hold_nxt  = 1'b0;
                        wake_nxt  = 1'b1;
                        vec_nxt   = GLOBAL_IRQ_ENABLE_I & irq_wake;
                        ost_nxt   = 11'h000;
                    end else begin
                        ost_nxt = ost_r + 11'h001;
                    end
                end
                default: begin
                    state_nxt = ST_RUN;
                end
            endcase
        end
        // Timeout wins over any same-cycle set of the flag
        if (wdt_timeout) begin
            to_flag_nxt = 1'b0;
        end
        sleep_nxt = (state_nxt != ST_RUN);
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_r   <= ST_RUN;
            ost_r     <= 11'h000;
            osc_en_r  <= 1'b1;
            hold_r    <= 1'b0;
            to_flag_r <= 1'b1;
            pd_flag_r <= 1'b1;
            rst_r     <= 1'b0;
            fetch_r   <= 1'b0;
            wake_r    <= 1'b0;
            vec_r     <= 1'b0;
            sleep_r   <= 1'b0;
        end else if (CE_I) begin
            state_r   <= state_nxt;
            ost_r     <= ost_nxt;
            osc_en_r  <= osc_en_nxt;
            hold_r    <= hold_nxt;
            to_flag_r <= to_flag_nxt;
            pd_flag_r <= pd_flag_nxt;
            rst_r     <= rst_nxt;
            fetch_r   <= fetch_nxt;
            wake_r    <= wake_nxt;
            vec_r     <= vec_nxt;
            sleep_r   <= sleep_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign DAT_O                   = dat_r;
    assign ACK_O                   = ack_r;
    assign TMR_INC_O               = tmr_inc_r;
    assign DEVICE_RESET_O          = rst_r;
    assign MAIN_OSC_DRIVE_EN_O     = osc_en_r;
    assign PORT_HOLD_O             = hold_r;
    assign SLEEPING_O              = sleep_r;
    assign FETCH_NEXT_O            = fetch_r;
    assign WAKE_O                  = wake_r;
    assign VECTOR_JUMP_O           = vec_r;
    assign TIMEOUT_STATUS_FLAG_O   = to_flag_r;
    assign POWERDOWN_STATUS_FLAG_O = pd_flag_r;

endmodule // wsw_top

// [tb/wsw_asserts.sv]
// Port-level assertions for the watchdog, sleep and wake block
`timescale 1ns/100ps

module wsw_asserts (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic MASTER_CLEAR_PIN_N_I,
    input wire logic GLOBAL_IRQ_ENABLE_I,
    input wire logic DEVICE_RESET_O,
    input wire logic MAIN_OSC_DRIVE_EN_O,
    input wire logic PORT_HOLD_O,
    input wire logic SLEEPING_O,
    input wire logic FETCH_NEXT_O,
    input wire logic WAKE_O,
    input wire logic VECTOR_JUMP_O,
    input wire logic TIMEOUT_STATUS_FLAG_O,
    input wire logic POWERDOWN_STATUS_FLAG_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // --------
    // Pin history
    // --------
    // Five quiet samples: the pin synchroniser has flushed by then
    sequence pin_high_s;
        MASTER_CLEAR_PIN_N_I [*5];
    endsequence
    sequence pin_low_s;
        !MASTER_CLEAR_PIN_N_I [*4];
    endsequence

    fetch_on_sleep_a: assert property ($rose(SLEEPING_O) |-> FETCH_NEXT_O)
        else $error("no prefetch on sleep entry");
    sleep_entry_a: assert property ($rose(SLEEPING_O) |->
        !POWERDOWN_STATUS_FLAG_O && TIMEOUT_STATUS_FLAG_O && !MAIN_OSC_DRIVE_EN_O)
        else $error("sleep entry flags or oscillator wrong");
    ports_held_a: assert property (SLEEPING_O |-> PORT_HOLD_O)
        else $error("ports released while asleep");
    wake_resumes_a: assert property (WAKE_O |->
        !SLEEPING_O && !PORT_HOLD_O && !DEVICE_RESET_O && MAIN_OSC_DRIVE_EN_O)
        else $error("wake did not resume cleanly");
    vector_gie_a: assert property (VECTOR_JUMP_O |-> WAKE_O && $past(GLOBAL_IRQ_ENABLE_I))
        else $error("vector without wake or global enable");
    wdt_reset_pulse_a: assert property (pin_high_s ##0 DEVICE_RESET_O |=>
        !DEVICE_RESET_O && !TIMEOUT_STATUS_FLAG_O)
        else $error("timeout reset not a pulse or flag kept");
    pin_reset_a: assert property (pin_low_s |=>
        DEVICE_RESET_O && !SLEEPING_O && MAIN_OSC_DRIVE_EN_O)
        else $error("low pin did not reset");
    pd_cleared_a: assert property ($fell(POWERDOWN_STATUS_FLAG_O) |-> $rose(SLEEPING_O))
        else $error("power-down flag fell outside sleep entry");
endmodule // wsw_asserts

// [tb/wsw_core_model.sv]
// Core stand-in: sleep and clear instructions, watchdog RC oscillator
`timescale 1ns/100ps

module wsw_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] cmd_i,
    input  wire logic       resume_i,
    output logic            sleep_o,
    output logic            clear_o,
    output logic            rc_osc_o
);
    logic parked_r;

    // Own free-running source, toggling every 100 ns in step with main clock falling edges
    initial begin
        {sleep_o, clear_o, parked_r, rc_osc_o} = 4'h0;
        forever #100 rc_osc_o = ~rc_osc_o;
    end

    always @(posedge clk_i) begin
        sleep_o <= 1'b0;
        clear_o <= 1'b0;
        if (!rst_n_i || resume_i) begin
            parked_r <= 1'b0;
        end else if (!parked_r) begin
            sleep_o  <= cmd_i == 2'h2;
            clear_o  <= cmd_i == 2'h1;
            // Only a no-op follows sleep until the core resumes
            parked_r <= cmd_i == 2'h2;
        end
    end
endmodule // wsw_core_model

// [tb/test_wsw_top.sv]
// Self-checking bench for the watchdog, sleep and wake block
`timescale 1ns/100ps

bind wsw_top wsw_asserts chk_u (.CLK_I, .RST_N_I, .MASTER_CLEAR_PIN_N_I, .GLOBAL_IRQ_ENABLE_I,
    .DEVICE_RESET_O, .MAIN_OSC_DRIVE_EN_O, .PORT_HOLD_O, .SLEEPING_O, .FETCH_NEXT_O, .WAKE_O,
    .VECTOR_JUMP_O, .TIMEOUT_STATUS_FLAG_O, .POWERDOWN_STATUS_FLAG_O);

module test_wsw_top;
    localparam int TICKS = 4;
    localparam int OST   = 4;
    logic        clk = 1'b0, rst_n = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        master_clear_pin_n = 1'b1, global_irq_enable = 1'b0, ack, sleep_in, clr_in, rc;
    logic        dev_rst, osc_en, hold, sleeping, wake, vec, tmr = 1'b0, inc;
    logic [1:0]  irq_en = 2'b00, irq_fl = 2'b00, cmd = 2'b00;
    logic [15:0] adr = 16'h0000;
    logic [31:0] dat = 32'h0000_0000, dat_o;
    int          failures = 0, check_count = 0, cycles_run = 0, rst_seen = 0;

    wsw_top #(.WDT_BASE_TICKS(TICKS), .OST_COUNT(OST)) dut_u (
        .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .ADR_I(adr), .DAT_I(dat), .SEL_I(4'hf),
        .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o), .ACK_O(ack),
        .WDT_RC_OSC_I(rc), .MASTER_CLEAR_PIN_N_I(master_clear_pin_n), .SLEEP_INSTR_I(sleep_in),
        .CLEAR_WATCHDOG_INSTR_I(clr_in), .GLOBAL_IRQ_ENABLE_I(global_irq_enable), .IRQ_ENABLE_I(irq_en),
        .IRQ_FLAG_I(irq_fl), .TMR_TICK_I(tmr), .TMR_WRITE_I(1'b0), .TMR_INC_O(inc),
        .DEVICE_RESET_O(dev_rst), .MAIN_OSC_DRIVE_EN_O(osc_en), .PORT_HOLD_O(hold),
        .SLEEPING_O(sleeping), .FETCH_NEXT_O(), .WAKE_O(wake), .VECTOR_JUMP_O(vec),
        .TIMEOUT_STATUS_FLAG_O(), .POWERDOWN_STATUS_FLAG_O());
    wsw_core_model core_u (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .resume_i(wake | dev_rst),
        .sleep_o(sleep_in), .clear_o(clr_in), .rc_osc_o(rc));

    initial forever #10 clk = ~clk;

    always @(posedge clk) begin
        cycles_run++;
        rst_seen <= rst_seen + int'(dev_rst === 1'b1);
        if (cycles_run == 20000) begin
            failures++;
            complete_run;
        end
    end

    task automatic complete_run;
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        dat <= {24'h00_0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic issue(input logic [1:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'b00;
    endtask

    // Bounded wait: sel 0 for a device reset, 1 for a wake
    task automatic wait_for(input int sel, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(sel == 0 ? dev_rst === 1'b1 : wake === 1'b1) && n < 600);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        wb(1'b0, 16'h000c, 8'h00, q);
        chk("status", q, 32'h18);
        wb(1'b0, 16'h0204, 8'h00, q);
        chk("option", q, 32'hff);
        wb(1'b1, 16'h0008, 8'h55, q);
        wb(1'b0, 16'h0008, 8'h00, q);
        chk("unmapped", q, 32'h0);
        wb(1'b1, 16'h801c, 8'hff, q);
        wb(1'b0, 16'h801c, 8'h00, q);
        chk("config", q, 32'h7f);
    endtask

    task automatic t_ratio;
        int n, r0, t;
        logic [31:0] q;
        for (int ps = 0; ps < 2; ps++) begin
            t = (TICKS << ps) * 10;
            wb(1'b1, 16'h0204, 8'h08 | 8'(ps), q);
            issue(2'h1);
            wait_for(0, n);
            chk("period", n >= t - 12 && n <= t + 8, 32'h1);
            wb(1'b0, 16'h000c, 8'h00, q);
            chk("timeout flag", q, 32'h08);
        end
        r0 = rst_seen;
        repeat (10) begin
            issue(2'h1);
            repeat (18) @(posedge clk);
        end
        chk("kick", rst_seen - r0, 32'h0);
        wb(1'b0, 16'h000c, 8'h00, q);
        chk("clear flags", q, 32'h18);
        wb(1'b1, 16'h0204, 8'hff, q);
        issue(2'h1);
    endtask

    task automatic t_fuse;
        int r0;
        logic [31:0] q;
        wb(1'b1, 16'h801c, 8'h7b, q);
        wb(1'b1, 16'h0204, 8'h08, q);
        r0 = rst_seen;
        repeat (200) @(posedge clk);
        chk("fuse off", rst_seen - r0, 32'h0);
        wb(1'b1, 16'h0204, 8'hff, q);
        wb(1'b1, 16'h801c, 8'h7f, q);
        issue(2'h1);
    endtask

    task automatic t_irq;
        int n;
        logic [31:0] q;
        global_irq_enable <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            irq_fl <= 2'(1 << s);
            issue(2'h2);
            repeat (4) @(posedge clk);
            chk("asleep", {sleeping, osc_en, hold}, 3'b101);
            wb(1'b0, 16'h000c, 8'h00, q);
            chk("sleep flags", q, 32'h10);
            irq_en <= 2'(1 << s);
            wait_for(1, n);
            chk("irq wake", {n <= 4, vec}, 2'b11);
        end
        global_irq_enable <= 1'b0;
        issue(2'h2);
        wait_for(1, n);
        chk("pending wake", {n <= 5, vec}, 2'b10);
        {irq_en, irq_fl} <= 4'h0;
    endtask

    task automatic t_wdt;
        int n, r0;
        logic [31:0] q;
        wb(1'b1, 16'h0204, 8'h08, q);
        issue(2'h1);
        issue(2'h2);
        r0 = rst_seen;
        wait_for(1, n);
        chk("wdt wake", {n <= 55, vec, rst_seen == r0}, 3'b101);
        wait_for(0, n);
        chk("wake zeroes", n >= 28 && n <= 50, 32'h1);
        wb(1'b0, 16'h000c, 8'h00, q);
        chk("wake flags", q, 32'h00);
        wb(1'b1, 16'h0204, 8'hff, q);
        issue(2'h1);
    endtask

    task automatic t_xtal;
        int n;
        logic [31:0] q;
        wb(1'b1, 16'h801c, 8'h7c, q);
        irq_fl <= 2'b01;
        issue(2'h2);
        repeat (3) @(posedge clk);
        irq_en <= 2'b01;
        wait_for(1, n);
        chk("start delay", n >= OST + 1 && n <= OST + 6, 32'h1);
        {irq_en, irq_fl} <= 4'h0;
        wb(1'b1, 16'h801c, 8'h7f, q);
    endtask

    task automatic t_master_clear_pin;
        issue(2'h2);
        repeat (3) @(posedge clk);
        master_clear_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("pin reset", {dev_rst, sleeping, osc_en, hold}, 4'b1010);
        master_clear_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("pin released", dev_rst, 32'h0);
    endtask

    // Timer owns the prescaler: ratio code 1 gives one increment per four ticks
    task automatic t_tmr;
        int k;
        logic [31:0] q;
        k = 0;
        issue(2'h1);
        wb(1'b1, 16'h0204, 8'h01, q);
        tmr <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            @(posedge clk);
            k += int'(inc === 1'b1);
            if (i == 15) tmr <= 1'b0;
        end
        chk("timer prescale", k, 32'h4);
        wb(1'b1, 16'h0204, 8'hff, q);
        issue(2'h1);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs;
        t_ratio;
        t_fuse;
        t_irq;
        t_wdt;
        t_xtal;
        t_master_clear_pin;
        t_tmr;
        complete_run;
    end
endmodule // test_wsw_top
